/* File: tcs_i2c_master.sv */
// Bus master model that stands on the far side of the register bus.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
// ==========================================================
// Bit-level master
module tcs_i2c_master (
  input wire logic clk, // Pacing clock
  input wire logic sda, // Resolved data wire
  output logic scl, // Bus clock drive
  output logic sda_pull // High pulls data low
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Half bit of 8 cycles, above the slave's 5-cycle minimum
  task automatic hp;
    repeat (8) @(negedge clk);
  endtask : hp
  // Start, also serves as repeated start
  task automatic start;
    sda_pull = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_pull = 1'b1;
    hp;
    scl = 1'b0;
    hp;
  endtask : start
  task automatic stop;
    sda_pull = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_pull = 1'b0;
    hp;
  endtask : stop
  // Data held 2 cycles past the fall, as sync skews clock and data
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask : bit_io
  // MSB first; ninth bit released, so reads always end with no ack
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : xfer
endmodule : tcs_i2c_master

/* File: tcs_pkg.sv */
// Constants, register map and state types for the cooler control logic.
// Assumes a 40 MHz system clock; every timing count derives from it here.
package tcs_pkg;

  // ==========================================================
  // Clocking and timing
  localparam int unsigned SYS_CLK_KHZ = 40000;
  localparam int unsigned BUCK_WAIT_US = 100;
  localparam int unsigned BUCK_WAIT_CYC =
    (BUCK_WAIT_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int unsigned DIS_SHORT_MS = 35;
  localparam int unsigned DIS_LONG_MS = 70;
  localparam int unsigned DIS_SHORT_CYC = DIS_SHORT_MS * SYS_CLK_KHZ;
  localparam int unsigned DIS_LONG_CYC = DIS_LONG_MS * SYS_CLK_KHZ;
  localparam int unsigned HIC_OFF_US = 2000;
  localparam int unsigned HIC_OFF_CYC = HIC_OFF_US * SYS_CLK_KHZ / 1000;
  localparam int unsigned SYNC_LOSS_NS = 2000;
  localparam int unsigned SYNC_LOSS_CYC = SYNC_LOSS_NS * SYS_CLK_KHZ / 1000000;
  localparam int unsigned INT_SW_KHZ = 1000;
  localparam int unsigned INT_HALF_CYC = SYS_CLK_KHZ / (2 * INT_SW_KHZ);
  localparam int TMR_W = 22;

  // ==========================================================
  // Bus address and register map
  localparam logic [6:0] DEV_ADDR = 7'h60;
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_HEAT_CURRENT_LIMIT_FLAG = 8'h01;
  localparam logic [7:0] OFS_COOL_CURRENT_LIMIT_FLAG = 8'h02;
  localparam logic [7:0] OFS_HEAT_VOLTAGE_LIMIT_FLAG = 8'h03;
  localparam logic [7:0] OFS_COOL_VOLTAGE_LIMIT_FLAG = 8'h04;
  localparam logic [7:0] OFS_CURRENT_MONITOR_ADC = 8'h07;
  localparam logic [7:0] OFS_VMON = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h09;

  // Writable bit masks; reserved bits are never stored
  localparam logic [7:0] SC_WMASK = 8'h1D;
  localparam logic [7:0] LIM_WMASK = 8'hBF;
  localparam logic [7:0] VLH_WMASK = 8'hFF;
  localparam logic [7:0] SC_RST = 8'h01;
  localparam logic [7:0] LIM_RST = 8'h00;

  // Field positions
  localparam int SC_ON_BIT = 0;
  localparam int SC_REFRESH_BIT = 1;
  localparam int SC_SS_LSB = 2;
  localparam int SC_DIS70_BIT = 4;
  localparam int LIM_EN_BIT = 7;
  localparam int VL_OVP_BIT = 6;
  localparam int LIM_VAL_MSB = 5;

  // ==========================================================
  // State types
  typedef enum logic [2:0] {
    TCS_I_IDLE, TCS_I_ADDR, TCS_I_REG, TCS_I_WDAT,
    TCS_I_ACK, TCS_I_RDAT, TCS_I_MACK
  } tcs_i2c_t;

  typedef enum logic [2:0] {
    TCS_P_OFF, TCS_P_DISCH, TCS_P_SOFT, TCS_P_RUN,
    TCS_P_HIC, TCS_P_OVP, TCS_P_OT
  } tcs_prot_t;

endpackage : tcs_pkg

/* File: tcs_top.sv */
// Control, protection sequencing, register bank and bus slave of the
// thermoelectric cooler driver. Assumes analog comparators and the ADC
// deliver levels; pins are resynchronised, the sync pin clocks a toggle.
//
// Functional notes
// - Severe overloads or secondary voltage force hiccup
// - Overvoltage: stop, discharge, then hiccup, soft start
// - Overtemperature shuts down, auto restarts when cool
// - Bus address 0x60, write C0 read C1
// - Control bit zero switches power stage
// - Stage runs only with enable, shutdown, on
// - Internal 1MHz clock, masked by external sync
// - Two bits select 1x 2x 4x 8x
// - Discharge on throughout every hiccup off period
// - Current limit value applies only when enabled
// - Voltage limit value applies only when enabled
// - Exceeded enabled limit overrides analog control input
// - Current monitor register holds ADC code
// - Voltage monitor register holds ADC code
// - Status top bits show heat or cool
// - Voltage limit flag latches on rising edge
// - Current limit flag latches on rising edge
// - Power good only in normal operation
// - Thermal fault flag latches until refresh
// - Thermal warning flag latches, no shutdown
// - Refresh bit pulses once, reads zero
// - Write applies at last data bit fall
// - Buck overload hiccups only after 100us
// - Discharge 35ms or 70ms before soft start
`timescale 1ns/1ps

module tcs_top #(
  parameter int unsigned DIS_SHORT_CYC = tcs_pkg::DIS_SHORT_CYC,
  parameter int unsigned DIS_LONG_CYC = tcs_pkg::DIS_LONG_CYC,
  parameter int unsigned HIC_OFF_CYC = tcs_pkg::HIC_OFF_CYC
) (
  input wire logic sys_clk, // System clock, 40 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic sync_clk, // Enable/sync pin as clock
  input wire logic en_sync_pin, // Enable/sync pin as level
  input wire logic shutdown_pin, // Shutdown pin, low stops stage
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Bus data drive value
  output logic sda_oe, // Bus data pull low enable
  input wire logic lin_ilim2_i, // Linear output second limit hit
  input wire logic buck_current_limit_flag_i, // Buck output current limit hit
  input wire logic vsec_lim_i, // Secondary voltage limit hit
  input wire logic ovp_i, // Input above 5.9V until below 5.6V
  input wire logic ot_i, // Overtemperature shutdown level
  input wire logic otw_i, // Overtemperature warning level
  input wire logic voltage_limit_flag_i, // Voltage limit indication
  input wire logic current_limit_flag_i, // Current limit indication
  input wire logic heat_i, // Heating direction detected
  input wire logic cool_i, // Cooling direction detected
  input wire logic ss1_done_i, // First soft-start stage done
  input wire logic [7:0] current_monitor_adc_code, // Current ADC code, sys_clk
  input wire logic [7:0] vmon_code, // Voltage ADC code, sys_clk
  output logic stage_on, // Power stage switching
  output logic discharge_en, // Output discharge path on
  output logic sw_clk, // Converter switching clock
  output logic [3:0] ss_mult, // One-hot soft-start multiplier
  output logic [7:0] heat_current_limit_flag, // Heat current limit register
  output logic [7:0] cool_current_limit_flag, // Cool current limit register
  output logic [7:0] heat_voltage_limit_flag, // Heat voltage limit register
  output logic [7:0] cool_voltage_limit_flag, // Cool voltage limit register
  output logic ctl_override // Regulate buck to limit value
);

  // ==========================================================
  // Pin synchronisers
  localparam int NPIN = 15;
  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2;
  logic scl_s, sda_s, en_s, sd_s, lin_s, buck_s, vsec_s, ovp_s;
  logic ot_s, otw_s, voltage_limit_flag_s, current_limit_flag_s, heat_s, cool_s, ss1_s;
  assign pin_raw = {scl_i, sda_i, en_sync_pin, shutdown_pin, lin_ilim2_i,
    buck_current_limit_flag_i, vsec_lim_i, ovp_i, ot_i, otw_i, voltage_limit_flag_i, current_limit_flag_i, heat_i,
    cool_i, ss1_done_i};
  assign {scl_s, sda_s, en_s, sd_s, lin_s, buck_s, vsec_s, ovp_s, ot_s,
    otw_s, voltage_limit_flag_s, current_limit_flag_s, heat_s, cool_s, ss1_s} = pin_s2;

  // Two stages per pin; only the second stage is read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // ==========================================================
  // Link domain: external sync clock toggles once per rising edge
  logic sync_tg_r;
  always_ff @(posedge sync_clk or posedge rst) begin
    if (rst) sync_tg_r <= 1'b0;
    else sync_tg_r <= ~sync_tg_r;
  end

  // Toggle crosses by two flops; a third gives the change event
  logic tg_s1_r, tg_s2_r, tg_s3_r, ext_act_r, int_clk_r, sw_clk_r;
  logic [7:0] loss_cnt_r;
  logic [4:0] half_cnt_r;
  wire tg_evt = tg_s2_r ^ tg_s3_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end else begin
      tg_s1_r <= sync_tg_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  // Sync seen recently masks the internal oscillator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loss_cnt_r <= 8'h00;
      ext_act_r <= 1'b0;
    end else if (tg_evt) begin
      loss_cnt_r <= 8'h00;
      ext_act_r <= 1'b1;
    end else if (loss_cnt_r == 8'(tcs_pkg::SYNC_LOSS_CYC)) begin
      ext_act_r <= 1'b0;
    end else begin
      loss_cnt_r <= loss_cnt_r + 8'h01;
    end
  end

  // Internal 1 MHz divider and clock selection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_cnt_r <= 5'h00;
      int_clk_r <= 1'b0;
      sw_clk_r <= 1'b0;
    end else begin
      half_cnt_r <= (half_cnt_r == 5'(tcs_pkg::INT_HALF_CYC - 1)) ? 5'h00 :
        half_cnt_r + 5'h01;
      if (half_cnt_r == 5'(tcs_pkg::INT_HALF_CYC - 1)) int_clk_r <= ~int_clk_r;
      sw_clk_r <= ext_act_r ? en_s : int_clk_r;
    end
  end
  assign sw_clk = sw_clk_r;

  // ==========================================================
  // Bus slave: oversampled start, stop and clock edges
  logic scl_q_r, sda_q_r, oe_r, rw_r, nack_r;
  logic [7:0] sh_r, ptr_r;
  logic [3:0] cnt_r;
  tcs_pkg::tcs_i2c_t ist_r, ack_to_r;
  wire scl_rise = scl_s & ~scl_q_r;
  wire scl_fall = ~scl_s & scl_q_r;
  wire bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire bus_stop = scl_s & scl_q_r & ~sda_q_r & sda_s;
  wire byte_in = (ist_r == tcs_pkg::TCS_I_ADDR) ||
    (ist_r == tcs_pkg::TCS_I_REG) || (ist_r == tcs_pkg::TCS_I_WDAT);
  wire byte_done = scl_fall & byte_in & (cnt_r == 4'h8);
  wire addr_hit = sh_r[7:1] == tcs_pkg::DEV_ADDR;
  wire wr_fire = byte_done & (ist_r == tcs_pkg::TCS_I_WDAT);
  logic [7:0] rd_data;

  // Protocol sequencing; acknowledge is held from fall to fall
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      ist_r <= tcs_pkg::TCS_I_IDLE;
      ack_to_r <= tcs_pkg::TCS_I_IDLE;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 4'h0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      if (bus_start) begin
        ist_r <= tcs_pkg::TCS_I_ADDR;
        cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (bus_stop) begin
        ist_r <= tcs_pkg::TCS_I_IDLE;
        oe_r <= 1'b0;
      end else if (scl_rise) begin
        if (byte_in) begin
          sh_r <= {sh_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end
        if (ist_r == tcs_pkg::TCS_I_MACK) nack_r <= sda_s;
      end else if (byte_done) begin
        oe_r <= (ist_r != tcs_pkg::TCS_I_ADDR) || addr_hit;
        ist_r <= tcs_pkg::TCS_I_ACK;
        case (ist_r)
          tcs_pkg::TCS_I_ADDR: begin
            rw_r <= sh_r[0];
            ack_to_r <= sh_r[0] ? tcs_pkg::TCS_I_RDAT : tcs_pkg::TCS_I_REG;
            if (!addr_hit) ist_r <= tcs_pkg::TCS_I_IDLE;
          end
          tcs_pkg::TCS_I_REG: begin
            ptr_r <= sh_r;
            ack_to_r <= tcs_pkg::TCS_I_WDAT;
          end
          default: begin
            ptr_r <= ptr_r + 8'h01;
            ack_to_r <= tcs_pkg::TCS_I_WDAT;
          end
        endcase
      end else if (scl_fall) begin
        case (ist_r)
          tcs_pkg::TCS_I_ACK: begin
            ist_r <= ack_to_r;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
            if (ack_to_r == tcs_pkg::TCS_I_RDAT) begin
              sh_r <= rd_data;
              oe_r <= ~rd_data[7];
              cnt_r <= 4'h1;
            end
          end
          tcs_pkg::TCS_I_RDAT: begin
            if (cnt_r == 4'h8) begin
              oe_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
              ist_r <= tcs_pkg::TCS_I_MACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              oe_r <= ~sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          tcs_pkg::TCS_I_MACK: begin
            if (nack_r) begin
              ist_r <= tcs_pkg::TCS_I_IDLE;
            end else begin
              ist_r <= tcs_pkg::TCS_I_RDAT;
              sh_r <= rd_data;
              oe_r <= ~rd_data[7];
              cnt_r <= 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;

  // ==========================================================
  // Register bank
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  logic [7:0] sc_r, hil_r, cil_r, hvl_r, cvl_r, stat_r;
  logic refresh_r;
  wire [7:0] wd = sh_r;

  // Writes land on the fall that ends the data byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sc_r <= tcs_pkg::SC_RST;
      hil_r <= tcs_pkg::LIM_RST;
      cil_r <= tcs_pkg::LIM_RST;
      hvl_r <= tcs_pkg::LIM_RST;
      cvl_r <= tcs_pkg::LIM_RST;
      refresh_r <= 1'b0;
    end else begin
      refresh_r <= wr_fire & hit(ptr_r, tcs_pkg::OFS_SYSCTL) &
        wd[tcs_pkg::SC_REFRESH_BIT];
      if (wr_fire) begin
        if (hit(ptr_r, tcs_pkg::OFS_SYSCTL))
          sc_r <= wd & tcs_pkg::SC_WMASK;
        if (hit(ptr_r, tcs_pkg::OFS_HEAT_CURRENT_LIMIT_FLAG))
          hil_r <= wd & tcs_pkg::LIM_WMASK;
        if (hit(ptr_r, tcs_pkg::OFS_COOL_CURRENT_LIMIT_FLAG))
          cil_r <= wd & tcs_pkg::LIM_WMASK;
        if (hit(ptr_r, tcs_pkg::OFS_HEAT_VOLTAGE_LIMIT_FLAG))
          hvl_r <= wd & tcs_pkg::VLH_WMASK;
        if (hit(ptr_r, tcs_pkg::OFS_COOL_VOLTAGE_LIMIT_FLAG))
          cvl_r <= wd & tcs_pkg::LIM_WMASK;
      end
    end
  end

  // Read selection; unmapped offsets read zero
  assign rd_data =
    hit(ptr_r, tcs_pkg::OFS_SYSCTL) ? sc_r :
    hit(ptr_r, tcs_pkg::OFS_HEAT_CURRENT_LIMIT_FLAG) ? hil_r :
    hit(ptr_r, tcs_pkg::OFS_COOL_CURRENT_LIMIT_FLAG) ? cil_r :
    hit(ptr_r, tcs_pkg::OFS_HEAT_VOLTAGE_LIMIT_FLAG) ? hvl_r :
    hit(ptr_r, tcs_pkg::OFS_COOL_VOLTAGE_LIMIT_FLAG) ? cvl_r :
    hit(ptr_r, tcs_pkg::OFS_CURRENT_MONITOR_ADC) ? current_monitor_adc_code :
    hit(ptr_r, tcs_pkg::OFS_VMON) ? vmon_code :
    hit(ptr_r, tcs_pkg::OFS_STATUS) ? stat_r : 8'h00;

  assign heat_current_limit_flag = hil_r;
  assign cool_current_limit_flag = cil_r;
  assign heat_voltage_limit_flag = hvl_r;
  assign cool_voltage_limit_flag = cvl_r;
  assign ss_mult = 4'h1 << sc_r[tcs_pkg::SC_SS_LSB +: 2];

  // Limits only count when their enable bit is set
  logic ovr_r;
  wire current_limit_flag_en = heat_s ? hil_r[tcs_pkg::LIM_EN_BIT] :
    cil_r[tcs_pkg::LIM_EN_BIT];
  wire voltage_limit_flag_en = heat_s ? hvl_r[tcs_pkg::LIM_EN_BIT] :
    cvl_r[tcs_pkg::LIM_EN_BIT];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ovr_r <= 1'b0;
    else ovr_r <= (current_limit_flag_s & current_limit_flag_en) | (voltage_limit_flag_s & voltage_limit_flag_en);
  end
  assign ctl_override = ovr_r;

  // ==========================================================
  // Protection and start-up sequencer
  tcs_pkg::tcs_prot_t ps_r;
  logic [tcs_pkg::TMR_W-1:0] tmr_r;
  logic [11:0] bcnt_r;
  wire run_ok = (en_s | ext_act_r) & sd_s & sc_r[tcs_pkg::SC_ON_BIT];
  wire ovp_on = ovp_s & hvl_r[tcs_pkg::VL_OVP_BIT];
  wire buck_long = bcnt_r == 12'(tcs_pkg::BUCK_WAIT_CYC - 1);
  wire severe = lin_s | vsec_s | (buck_s & buck_long);
  wire live = (ps_r == tcs_pkg::TCS_P_SOFT) || (ps_r == tcs_pkg::TCS_P_RUN);
  wire [tcs_pkg::TMR_W-1:0] dis_len = sc_r[tcs_pkg::SC_DIS70_BIT] ?
    tcs_pkg::TMR_W'(DIS_LONG_CYC - 1) : tcs_pkg::TMR_W'(DIS_SHORT_CYC - 1);
  wire tmr_end = (ps_r == tcs_pkg::TCS_P_DISCH) ? (tmr_r == dis_len) :
    (tmr_r == tcs_pkg::TMR_W'(HIC_OFF_CYC - 1));

  // Buck overload must persist before it counts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) bcnt_r <= 12'h000;
    else if (!(buck_s && live)) bcnt_r <= 12'h000;
    else if (!buck_long) bcnt_r <= bcnt_r + 12'h001;
  end

  // Sequencer; standby and thermal shutdown take priority
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ps_r <= tcs_pkg::TCS_P_OFF;
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + 1'b1;
      if (!run_ok) begin
        ps_r <= tcs_pkg::TCS_P_OFF;
      end else if (ot_s) begin
        ps_r <= tcs_pkg::TCS_P_OT;
      end else begin
        case (ps_r)
          tcs_pkg::TCS_P_OFF, tcs_pkg::TCS_P_OT: begin
            ps_r <= tcs_pkg::TCS_P_DISCH;
            tmr_r <= '0;
          end
          tcs_pkg::TCS_P_DISCH: if (tmr_end) ps_r <= tcs_pkg::TCS_P_SOFT;
          tcs_pkg::TCS_P_OVP: if (!ovp_on) begin
            ps_r <= tcs_pkg::TCS_P_HIC;
            tmr_r <= '0;
          end
          tcs_pkg::TCS_P_HIC: if (tmr_end) begin
            ps_r <= ovp_on ? tcs_pkg::TCS_P_OVP : tcs_pkg::TCS_P_SOFT;
            tmr_r <= '0;
          end
          default: begin
            if (ovp_on) ps_r <= tcs_pkg::TCS_P_OVP;
            else if (severe) begin
              ps_r <= tcs_pkg::TCS_P_HIC;
              tmr_r <= '0;
            end else if (ss1_s) ps_r <= tcs_pkg::TCS_P_RUN;
          end
        endcase
      end
    end
  end
  assign stage_on = live;
  assign discharge_en = (ps_r == tcs_pkg::TCS_P_DISCH) ||
    (ps_r == tcs_pkg::TCS_P_HIC) || (ps_r == tcs_pkg::TCS_P_OVP);

  // ==========================================================
  // Status flags; a new event wins over a refresh in the same cycle
  logic voltage_limit_flag_q_r, current_limit_flag_q_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_r <= 8'h00;
      voltage_limit_flag_q_r <= 1'b0;
      current_limit_flag_q_r <= 1'b0;
    end else begin
      voltage_limit_flag_q_r <= voltage_limit_flag_s;
      current_limit_flag_q_r <= current_limit_flag_s;
      stat_r[7] <= heat_s & ~cool_s;
      stat_r[6] <= cool_s & ~heat_s;
      stat_r[5] <= (voltage_limit_flag_s & ~voltage_limit_flag_q_r) | (stat_r[5] & ~refresh_r);
      stat_r[4] <= (current_limit_flag_s & ~current_limit_flag_q_r) | (stat_r[4] & ~refresh_r);
      stat_r[3] <= ps_r == tcs_pkg::TCS_P_RUN;
      stat_r[2] <= 1'b0;
      stat_r[1] <= ot_s | (stat_r[1] & ~refresh_r);
      stat_r[0] <= otw_s | (stat_r[0] & ~refresh_r);
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wr_sysctl;
    wr_fire && hit(ptr_r, tcs_pkg::OFS_SYSCTL);
  endsequence

  AST_ON_BIT: assert property (s_wr_sysctl |=>
    sc_r[tcs_pkg::SC_ON_BIT] == $past(wd[tcs_pkg::SC_ON_BIT]))
    else $error("on bit not written");
  AST_REFRESH_PULSE: assert property (s_wr_sysctl and
    wd[tcs_pkg::SC_REFRESH_BIT] |=> refresh_r ##1 !refresh_r)
    else $error("refresh not a single pulse");
  AST_STAGE_GATE: assert property (stage_on |-> $past(run_ok))
    else $error("stage active without enables");
  AST_HICCUP_ENTRY: assert property (live && run_ok && !ot_s &&
    !ovp_on && (lin_s || vsec_s) |=> ps_r == tcs_pkg::TCS_P_HIC)
    else $error("severe fault missed hiccup");
  AST_BUCK_WAIT: assert property (ps_r == tcs_pkg::TCS_P_RUN &&
    !buck_s ##1 buck_s && !lin_s && !vsec_s && !ovp_on && !ot_s && run_ok
    |=> ps_r == tcs_pkg::TCS_P_RUN)
    else $error("buck limit acted without wait");
  // A non-thermal fault stop with enables held must land in a discharging state
  AST_DISCH_HIC: assert property ($fell(stage_on) &&
    $past(run_ok) && !$past(ot_s) |-> discharge_en)
    else $error("no discharge after fault stop");
  AST_VOLTAGE_LIMIT_FLAG_LATCH: assert property ($rose(voltage_limit_flag_s) |=> stat_r[5] ##1
    (stat_r[5] || $past(refresh_r)))
    else $error("voltage limit flag not latched");
  AST_OT_LATCH: assert property (ot_s && !refresh_r |=>
    stat_r[1] && ps_r != tcs_pkg::TCS_P_RUN)
    else $error("thermal fault not latched");
  AST_POWER_GOOD_FLAG: assert property (stat_r[3] |-> $past(run_ok, 2) &&
    !$past(ot_s, 2))
    else $error("power good outside normal run");

endmodule : tcs_top

/* File: tec_control_status_logic_tb_top.sv */
// Self-checking bench for the cooler control and status logic.
// Assumes tcs_top with short timing counts and the bus master model.
`timescale 1ns/1ps
module tec_control_status_logic_tb_top;
  logic sys_clk, rst, lclk, en_lvl, sync_run, shutdown_pin, ss1, heat;
  logic current_limit_flag, voltage_limit_flag, ot, thermal_warning_flag, lin2, buck, a, cool, vsec, input_overvoltage_protection, sw_clk;
  logic [7:0] current_monitor_adc = 8'h3C, vmon = 8'hA5, q, heat_current_limit_flag;
  logic [7:0] cool_current_limit_flag, heat_voltage_limit_flag, cool_voltage_limit_flag;
  logic [3:0] ss_mult;
  logic sda_oe, stage_on, discharge_en, ctl_override;
  wire scl, m_pull;
  int fails = 0, total_checks = 0, cyc = 0;
  // Enable pin carries a level or, within bursts, the link clock
  wire en_pin = sync_run ? lclk : en_lvl;
  wire sda = ~(m_pull | sda_oe);
  // ==========================================================
  // Clocks and models
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    lclk = 1'b0;
    forever #6 lclk = ~lclk;
  end
  tcs_i2c_master M (.clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(m_pull));
  // Short counts keep discharge and hiccup waits brief
  tcs_top #(.DIS_SHORT_CYC(50), .DIS_LONG_CYC(100), .HIC_OFF_CYC(40)) DUT (
    .sys_clk(sys_clk), .rst(rst), .sync_clk(en_pin), .en_sync_pin(en_pin),
    .shutdown_pin(shutdown_pin), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .lin_ilim2_i(lin2), .buck_current_limit_flag_i(buck),
    .vsec_lim_i(vsec), .ovp_i(input_overvoltage_protection), .ot_i(ot), .otw_i(thermal_warning_flag), .voltage_limit_flag_i(voltage_limit_flag),
    .current_limit_flag_i(current_limit_flag), .heat_i(heat), .cool_i(cool), .ss1_done_i(ss1),
    .current_monitor_adc_code(current_monitor_adc), .vmon_code(vmon), .stage_on(stage_on),
    .discharge_en(discharge_en), .sw_clk(sw_clk), .ss_mult(ss_mult),
    .heat_current_limit_flag(heat_current_limit_flag), .cool_current_limit_flag(cool_current_limit_flag), .heat_voltage_limit_flag(heat_voltage_limit_flag),
    .cool_voltage_limit_flag(cool_voltage_limit_flag), .ctl_override(ctl_override));
  // ==========================================================
  // Checks, bus tasks and closing
  task automatic chk8(input logic [7:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, e, input string m);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %b", $time, m, g);
    end
  endtask : chk1
  task automatic wr(input logic [7:0] o, d);
    M.start;
    M.xfer(8'hC0, q, a);
    M.xfer(o, q, a);
    M.xfer(d, q, a);
    M.stop;
    chk1(a, 1'b1, "data ack");
  endtask : wr
  task automatic rd(input logic [7:0] o, e);
    M.start;
    M.xfer(8'hC0, q, a);
    M.xfer(o, q, a);
    M.start;
    M.xfer(8'hC1, q, a);
    M.xfer(8'hFF, q, a);
    M.stop;
    chk8(q, e, "read");
  endtask : rd
  // Counts switching clock changes over 400 cycles
  task automatic chk_sw(input logic [7:0] e);
    logic p;
    logic [7:0] n;
    p = sw_clk;
    n = 8'h00;
    repeat (400) begin
      @(negedge sys_clk);
      if (sw_clk !== p) n++;
      p = sw_clk;
    end
    chk8(n, e, "sw clk");
  endtask : chk_sw
  // Bounded wait for the power stage to reach a level
  task automatic wait_on(input logic e, input int n);
    for (int k = 0; k < n && stage_on !== e; k++) @(negedge sys_clk);
    chk1(stage_on, e, "stage");
  endtask : wait_on
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // Hang guard, well above the expected 30k cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      $display("CHECK FAILED t=%0t timeout", $time);
      fails++;
      print_verdict;
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    {rst, en_lvl, shutdown_pin, ss1} = 4'hF;
    {sync_run, heat, current_limit_flag, voltage_limit_flag, ot, thermal_warning_flag, lin2, buck} = 8'h00;
    {cool, vsec, input_overvoltage_protection} = 3'h0;
    step(20);
    rst = 1'b0;
    step(4);
    rd(8'h00, 8'h01);
    chk_sw(8'h14);
    for (int i = 1; i <= 4; i++) begin
      rd(i[7:0], 8'h00);
      wr(i[7:0], 8'hFF);
      rd(i[7:0], (i == 3) ? 8'hFF : 8'hBF);
    end
    chk8(heat_current_limit_flag, 8'hBF, "limit port");
    chk8(cool_current_limit_flag, 8'hBF, "cool current_limit_flag port");
    chk8(heat_voltage_limit_flag, 8'hFF, "heat voltage_limit_flag port");
    chk8(cool_voltage_limit_flag, 8'hBF, "cool voltage_limit_flag port");
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {4'h0, i[1:0], 2'b01});
      chk8({4'h0, ss_mult}, 8'h01 << i, "ss mult");
    end
    rd(8'h00, 8'h0D);
    wr(8'h07, 8'h55);
    wr(8'h06, 8'h55);
    rd(8'h07, 8'h3C);
    rd(8'h08, 8'hA5);
    M.start;
    M.xfer(8'hA0, q, a);
    M.stop;
    chk1(a, 1'b0, "foreign address");
    shutdown_pin = 1'b0;
    wait_on(1'b0, 6);
    shutdown_pin = 1'b1;
    step(45);
    chk1(discharge_en, 1'b1, "discharge");
    wait_on(1'b1, 20);
    lin2 = 1'b1;
    wait_on(1'b0, 6);
    lin2 = 1'b0;
    step(30);
    chk1(discharge_en, 1'b1, "hiccup discharge");
    wait_on(1'b1, 20);
    buck = 1'b1;
    step(3900);
    chk1(stage_on, 1'b1, "buck wait");
    wait_on(1'b0, 200);
    buck = 1'b0;
    wait_on(1'b1, 100);
    vsec = 1'b1;
    wait_on(1'b0, 6);
    vsec = 1'b0;
    wait_on(1'b1, 100);
    input_overvoltage_protection = 1'b1;
    wait_on(1'b0, 6);
    chk1(discharge_en, 1'b1, "ovp discharge");
    step(50);
    chk1(stage_on, 1'b0, "ovp hold");
    input_overvoltage_protection = 1'b0;
    wait_on(1'b1, 100);
    {sync_run, en_lvl} = 2'b10;
    step(100);
    chk1(stage_on, 1'b1, "sync run");
    sync_run = 1'b0;
    wait_on(1'b0, 100);
    en_lvl = 1'b1;
    wr(8'h00, 8'h00);
    wait_on(1'b0, 10);
    wr(8'h00, 8'h01);
    wait_on(1'b1, 100);
    wr(8'h01, 8'h85);
    {heat, current_limit_flag} = 2'b11;
    step(6);
    chk1(ctl_override, 1'b1, "override");
    wr(8'h01, 8'h05);
    chk1(ctl_override, 1'b0, "override off");
    {current_limit_flag, voltage_limit_flag, thermal_warning_flag, ot} = 4'b0111;
    wait_on(1'b0, 6);
    step(4);
    {voltage_limit_flag, thermal_warning_flag, ot} = 3'b000;
    wait_on(1'b1, 100);
    rd(8'h09, 8'hBB);
    wr(8'h00, 8'h03);
    rd(8'h09, 8'h88);
    rd(8'h00, 8'h01);
    voltage_limit_flag = 1'b1;
    step(4);
    voltage_limit_flag = 1'b0;
    rd(8'h09, 8'hA8);
    wr(8'h00, 8'h03);
    heat = 1'b0;
    rd(8'h09, 8'h08);
    cool = 1'b1;
    rd(8'h09, 8'h48);
    wr(8'h00, 8'h11);
    shutdown_pin = 1'b0;
    wait_on(1'b0, 6);
    shutdown_pin = 1'b1;
    step(95);
    chk1(discharge_en, 1'b1, "long discharge");
    wait_on(1'b1, 20);
    print_verdict;
  end
endmodule : tec_control_status_logic_tb_top
